// *** core/adc_ctx_ctrl.sv ***
// injected context queue, conversion timing and status flags
`default_nettype none
// Functional notes
// [R1] two-entry context queue; full-queue write dropped, sets overflow flag
// [R2] retain mode keeps last context; empty mode blocks triggers when empty
// [R3] injected stop or converter disable flushes the queue; retain mode keeps the active context
// [R4] context read shows active context or zero when none
// [R5] overflow flag tells whether each context write was discarded
// [R6] software writes third context only after injected sequence done
// [R7] software keeps triggers away while an immediate context write happens
// [R8] after stop, software conversion starts only on start rising edge
// [R9] software sets injected start to re-enable hardware triggers
// [R10] trigger edge zero means software trigger, nonzero hardware trigger
// [R11] empty start procedure in retain mode uses dummy context
// [R12] two-bit resolution selects 12, 10, 8 or 6 bits
// [R13] approximation lasts 12.5, 10.5, 8.5 or 6.5 cycles
// [R14] full conversion takes 14, 12, 10 or 8 cycles
// [R15] regular conversion done flag set on regular data, interrupt if enabled
// [R16] regular done flag clears on write one or result read
// [R17] injected done flag set on injected data, clears on write or read
// [R18] sampling done flag for regular conversions, write-one clear
// [R19] regular sequence done flag on last regular data, write-one clear
// [R20] injected sequence done flag on last injected data, write-one clear
// [R21] resolution code 00=12, 01=10, 10=8, 11=6 bits
module adc_ctx_ctrl
(
   // clock and reset
   input  wire logic                         clk_sys_in,
   input  wire logic                         rstn_in,
   // configuration
   input  wire logic                         queue_empty_mode_in,
   input  wire logic [1:0]                   resolution_in,
   input  wire logic                         converter_disable_in,
   input  wire logic                         injected_start_in,
   input  wire logic                         injected_stop_in,
   input  wire logic                         regular_start_in,
   input  wire logic                         regular_last_in,
   input  wire logic                         injected_last_in,
   input  wire logic                         hw_trigger_in,
   // context register access
   input  wire logic                         ctx_write_in,
   input  wire logic [31:0]                  ctx_wdata_in,
   // flag clears and result reads
   input  wire adc_ctx_pkg::flags_type       flag_clear_in,
   input  wire logic                         regular_result_read_in,
   input  wire logic                         injected_result_read_in,
   // interrupt enables
   input  wire adc_ctx_pkg::flags_type       irq_en_in,
   // status
   output logic [31:0]                       injected_context_reg_out,
   output adc_ctx_pkg::flags_type            flags_out,
   output logic                              irq_out,
   output logic                              busy_out,
   output logic                              conv_is_injected_out,
   output logic                              injected_start_out
);

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_SAR    = 3'b100
   } state_type;

   logic [31:0] slot_q [2];
   logic [31:0] slot_d [2];
   logic [1:0]  count_q, count_d;
   logic        hold_q, hold_d;
   state_type   state_q, state_d;
   logic [4:0]  half_q, half_d;
   logic        inj_q, inj_d;
   logic        last_q, last_d;
   logic        start_q, start_d;
   logic        start_prev_q, start_prev_d;
   logic        armed_q, armed_d;
   adc_ctx_pkg::flags_type flags_q, flags_d;
   logic        irq_q, irq_d;
   logic [4:0]  sar_half;
   logic        sw_ctx, trig_ok, inj_go, reg_go, flush, done, rise;
   logic        write_ok, consume;
   adc_ctx_pkg::flags_type set_ev;

   always_comb
   begin
      case (resolution_in) // R21
         adc_ctx_pkg::RES_12: sar_half = adc_ctx_pkg::SAR_HALF_12; // R12 R13
         adc_ctx_pkg::RES_10: sar_half = adc_ctx_pkg::SAR_HALF_10;
         adc_ctx_pkg::RES_8:  sar_half = adc_ctx_pkg::SAR_HALF_8;
         default:             sar_half = adc_ctx_pkg::SAR_HALF_6;
      endcase
   end

   // context queue and trigger qualification
   always_comb
   begin
      flush = injected_stop_in | converter_disable_in; // R3
      sw_ctx = slot_q[0][adc_ctx_pkg::TRIG_EDGE_LSB +: 2]
               == adc_ctx_pkg::TRIG_EDGE_SW; // R10
      trig_ok = (count_q != 2'h0) | hold_q; // R2
      start_d = injected_start_in & ~flush;
      // edge seen on the bit itself, so a flush cannot fake a new edge
      start_prev_d = injected_start_in;
      rise = injected_start_in & ~start_prev_q; // R8
      armed_d = armed_q;
      if (flush)
         armed_d = 1'b0;
      else if (rise)
         armed_d = 1'b1; // R8 R9
      inj_go = trig_ok & ~flush & (state_q == ST_IDLE) &
               (sw_ctx ? rise : ((armed_q | rise) & hw_trigger_in)); // R8
      reg_go = regular_start_in & ~inj_go & (state_q == ST_IDLE);
      done = (state_q == ST_SAR) & (half_q <= 5'h02);
      consume = done & inj_q & last_q;
      write_ok = ctx_write_in & (count_q != 2'h2); // R1
      slot_d[0] = slot_q[0];
      slot_d[1] = slot_q[1];
      count_d = count_q;
      hold_d = hold_q;
      if (consume & (count_q == 2'h2))
      begin
         slot_d[0] = slot_q[1];
         count_d = 2'h1;
      end
      else if (consume & (count_q == 2'h1) & queue_empty_mode_in)
         count_d = 2'h0; // R2
      if (write_ok)
      begin
         if (count_d == 2'h0)
         begin
            slot_d[0] = ctx_wdata_in;
            count_d = 2'h1;
         end
         else
         begin
            slot_d[1] = ctx_wdata_in;
            count_d = 2'h2;
         end
      end
      hold_d = ~queue_empty_mode_in & (hold_q | (count_d != 2'h0)); // R2
      if (flush)
      begin
         count_d = queue_empty_mode_in ? 2'h0 : {1'b0, |count_q}; // R3
      end
   end

   // conversion timing in half cycles
   always_comb
   begin
      state_d = state_q;
      half_d = half_q;
      inj_d = inj_q;
      last_d = last_q;
      set_ev = '0;
      case (state_q)
         ST_IDLE:
         begin
            if (inj_go | reg_go)
            begin
               state_d = ST_SAMPLE;
               half_d = adc_ctx_pkg::SAMP_HALF_MIN; // R14
               inj_d = inj_go;
               last_d = inj_go ? injected_last_in : regular_last_in;
            end
         end
         ST_SAMPLE:
         begin
            if (half_q <= 5'h02)
            begin
               state_d = ST_SAR;
               half_d = sar_half + (half_q - 5'h02);
               set_ev.sampling_done = ~inj_q; // R18
            end
            else
               half_d = half_q - 5'h02;
         end
         ST_SAR:
         begin
            if (done)
            begin
               state_d = ST_IDLE;
               set_ev.regular_conv_done = ~inj_q; // R15
               set_ev.regular_seq_done = ~inj_q & last_q; // R19
               set_ev.injected_conv_done = inj_q; // R17
               set_ev.injected_seq_done = inj_q & last_q; // R20
            end
            else
               half_d = half_q - 5'h02;
         end
         default: state_d = ST_IDLE;
      endcase
      if (converter_disable_in)
         state_d = ST_IDLE;
      set_ev.queue_overflow_flag = ctx_write_in & ~write_ok; // R1 R5
   end

   // sticky flags, set wins over clear
   always_comb
   begin
      flags_d = flags_q & ~flag_clear_in; // R18 R19 R20
      if (regular_result_read_in)
         flags_d.regular_conv_done = 1'b0; // R16
      if (injected_result_read_in)
         flags_d.injected_conv_done = 1'b0; // R17
      if (write_ok)
         flags_d.queue_overflow_flag = 1'b0; // R5
      flags_d = flags_d | set_ev;
      irq_d = |(flags_d & irq_en_in); // R15
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rstn_in)
      begin
         slot_q[0] <= adc_ctx_pkg::CTX_EMPTY;
         slot_q[1] <= adc_ctx_pkg::CTX_EMPTY;
         count_q <= 2'h0;
         hold_q <= 1'b0;
         state_q <= ST_IDLE;
         half_q <= 5'h00;
         inj_q <= 1'b0;
         last_q <= 1'b0;
         start_q <= 1'b0;
         start_prev_q <= 1'b0;
         armed_q <= 1'b0;
         flags_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         slot_q[0] <= slot_d[0];
         slot_q[1] <= slot_d[1];
         count_q <= count_d;
         hold_q <= hold_d;
         state_q <= state_d;
         half_q <= half_d;
         inj_q <= inj_d;
         last_q <= last_d;
         start_q <= start_d;
         start_prev_q <= start_prev_d;
         armed_q <= armed_d;
         flags_q <= flags_d;
         irq_q <= irq_d;
      end
   end

   logic [31:0] ctx_out_q;
   logic        busy_q;
   always_ff @(posedge clk_sys_in)
   begin
      if (!rstn_in)
      begin
         ctx_out_q <= adc_ctx_pkg::CTX_EMPTY;
         busy_q <= 1'b0;
      end
      else
      begin
         ctx_out_q <= (count_d != 2'h0) ? slot_d[0]
                                         : adc_ctx_pkg::CTX_EMPTY; // R4
         busy_q <= state_d != ST_IDLE;
      end
   end

   assign injected_context_reg_out = ctx_out_q;
   assign flags_out = flags_q;
   assign irq_out = irq_q;
   assign busy_out = busy_q;
   assign conv_is_injected_out = inj_q;
   assign injected_start_out = start_q;

   chk_overflow_drop: assert property (@(posedge clk_sys_in) // R1
      disable iff (!rstn_in) ctx_write_in && count_q == 2'h2
      && !consume && !flush
      |=> flags_q.queue_overflow_flag && count_q == 2'h2)
      else $error("full queue write not dropped");
   chk_overflow_clear: assert property (@(posedge clk_sys_in) // R5
      disable iff (!rstn_in) write_ok |=> !flags_q.queue_overflow_flag)
      else $error("accepted write left overflow set");
   chk_flush_empty: assert property (@(posedge clk_sys_in) // R3
      disable iff (!rstn_in) flush && queue_empty_mode_in
      |=> count_q == 2'h0)
      else $error("flush did not empty queue");
   chk_ctx_zero: assert property (@(posedge clk_sys_in) // R4
      disable iff (!rstn_in) count_q == 2'h0 && !hold_q
      |-> ctx_out_q == adc_ctx_pkg::CTX_EMPTY)
      else $error("empty context not read as zero");
   chk_empty_block: assert property (@(posedge clk_sys_in) // R2
      disable iff (!rstn_in) count_q == 2'h0 |-> !inj_go)
      else $error("trigger taken with empty queue");
   chk_conv_12: assert property (@(posedge clk_sys_in) // R14
      disable iff (!rstn_in) state_q == ST_IDLE && (inj_go || reg_go)
      && resolution_in == adc_ctx_pkg::RES_12 && !converter_disable_in
      ##1 (resolution_in == adc_ctx_pkg::RES_12 && !converter_disable_in) [*8]
      ##1 !converter_disable_in [*5]
      |-> ##1 state_q == ST_SAR ##1 state_q == ST_IDLE)
      else $error("12-bit conversion length wrong");
   chk_regular_read: assert property (@(posedge clk_sys_in) // R16
      disable iff (!rstn_in) regular_result_read_in
      && !set_ev.regular_conv_done |=> !flags_q.regular_conv_done)
      else $error("result read did not clear done flag");
   chk_seq_done: assert property (@(posedge clk_sys_in) // R20
      disable iff (!rstn_in) done && inj_q && last_q
      |=> flags_q.injected_seq_done && flags_q.injected_conv_done)
      else $error("injected sequence done not set");
   cov_overflow: cover property (@(posedge clk_sys_in)
      ctx_write_in && count_q == 2'h2);
   cov_inj_done: cover property (@(posedge clk_sys_in)
      set_ev.injected_seq_done);
   cov_flush: cover property (@(posedge clk_sys_in) flush && count_q != 2'h0);
endmodule : adc_ctx_ctrl
`default_nettype wire

// *** core/adc_ctx_pkg.sv ***
// constants and carrier types for the injected context queue and flags
`default_nettype none
package adc_ctx_pkg;
   localparam int CTX_W = 32;
   localparam int QUEUE_DEPTH = 2;
   localparam logic [31:0] CTX_EMPTY = 32'h0000_0000;
   localparam int TRIG_EDGE_LSB = 6;
   localparam logic [1:0] TRIG_EDGE_SW = 2'h0;
   // approximation phase in half cycles per resolution code
   localparam logic [4:0] SAR_HALF_12 = 5'h19;
   localparam logic [4:0] SAR_HALF_10 = 5'h15;
   localparam logic [4:0] SAR_HALF_8 = 5'h11;
   localparam logic [4:0] SAR_HALF_6 = 5'h0d;
   localparam logic [4:0] SAMP_HALF_MIN = 5'h03;
   localparam logic [1:0] RES_12 = 2'h0;
   localparam logic [1:0] RES_10 = 2'h1;
   localparam logic [1:0] RES_8 = 2'h2;
   localparam logic [1:0] RES_6 = 2'h3;

   typedef struct packed {
      logic sampling_done;
      logic regular_conv_done;
      logic regular_seq_done;
      logic injected_conv_done;
      logic injected_seq_done;
      logic queue_overflow_flag;
   } flags_type;
endpackage : adc_ctx_pkg
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the injected context queue and flags
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  clk_sys_in = 0;
   logic                  rstn_in = 0;
   logic                  qmode = 0, dis = 0, jstart = 0, jstop = 0;
   logic                  rstart = 0, rlast = 0, jlast = 0, htrig = 0;
   logic                  wr_en = 0, rrd = 0, jrd = 0;
   logic [1:0]            res = 2'h0;
   logic [31:0]           wdata = 32'h0000_0000;
   adc_ctx_pkg::flags_type clr = '0, ien = '0, fl;
   logic [31:0]           ctx;
   logic                  irq, busy, is_inj, jst;
   int                    mismatches = 0, comparisons = 0, n, t [4];
   localparam logic [31:0] HW1 = 32'h0000_0041;
   localparam logic [31:0] HW2 = 32'h0000_0082;
   localparam logic [31:0] HW3 = 32'h0000_00c3;
   localparam logic [31:0] SW1 = 32'h0000_0005;

   adc_ctx_ctrl dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .queue_empty_mode_in(qmode), .resolution_in(res),
      .converter_disable_in(dis), .injected_start_in(jstart),
      .injected_stop_in(jstop), .regular_start_in(rstart),
      .regular_last_in(rlast), .injected_last_in(jlast),
      .hw_trigger_in(htrig), .ctx_write_in(wr_en), .ctx_wdata_in(wdata),
      .flag_clear_in(clr), .regular_result_read_in(rrd),
      .injected_result_read_in(jrd), .irq_en_in(ien),
      .injected_context_reg_out(ctx), .flags_out(fl), .irq_out(irq),
      .busy_out(busy), .conv_is_injected_out(is_inj),
      .injected_start_out(jst));

   initial
   begin
      forever #4 clk_sys_in = ~clk_sys_in;
   end

   task step;
      @(posedge clk_sys_in);
      #1;
   endtask : step

   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk

   task wr(input logic [31:0] d);
      wdata = d;
      wr_en = 1;
      step;
      wr_en = 0;
      step;
   endtask : wr

   // waits a bounded time for one flag bit, counting cycles
   task wait_flag(input int b, output int c);
      c = 0;
      while (fl[b] !== 1'b1 && c < 40)
      begin
         step;
         c++;
      end
      if (c >= 40)
         chk(1'b0, 1'b1, "flag never set");
   endtask : wait_flag

   task clear_all;
      clr = '1;
      step;
      clr = '0;
      step;
   endtask : clear_all

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #200000;
      mismatches++;
      tally_and_finish;
   end

   initial
   begin
      repeat (20) step;
      rstn_in = 1;
      step;
      chk(ctx, 32'h0000_0000, "context not empty after reset");
      chk({26'h0, fl}, 32'h0000_0000, "flags after reset");
      // two contexts fit, a third is dropped
      wr(HW1);
      chk(ctx, HW1, "first write not active");
      chk(fl.queue_overflow_flag, 1'b0, "overflow on first");
      wr(HW2);
      chk(fl.queue_overflow_flag, 1'b0, "overflow on second");
      wr(HW3);
      chk(fl.queue_overflow_flag, 1'b1, "no overflow on third");
      chk(ctx, HW1, "overflow changed context");
      clear_all;
      $display("queue test done");
      // hardware injected conversion
      ien.injected_conv_done = 1;
      jlast = 1;
      jstart = 1;
      step;
      htrig = 1;
      step;
      htrig = 0;
      wait_flag(1, n);
      chk(fl.injected_conv_done, 1'b1, "injected done missing");
      chk(fl.sampling_done, 1'b0, "sampling flag on injected");
      chk(irq, 1'b1, "injected irq missing");
      chk(ctx, HW2, "queue not consumed");
      jrd = 1;
      step;
      jrd = 0;
      step;
      chk(fl.injected_conv_done, 1'b0, "read did not clear");
      chk(fl.injected_seq_done, 1'b1, "seq flag lost");
      clear_all;
      chk(fl.injected_seq_done, 1'b0, "seq flag not cleared");
      ien = '0;
      $display("injected test done");
      // regular conversions at every resolution
      rlast = 1;
      ien.regular_conv_done = 1;
      for (int r = 0; r < 4; r++)
      begin
         res = r[1:0];
         step;
         rstart = 1;
         step;
         rstart = 0;
         wait_flag(4, t[r]);
         chk(irq, 1'b1, "regular irq missing");
         chk(fl.sampling_done, 1'b1, "sampling flag missing");
         chk(fl.regular_seq_done, 1'b1, "regular seq missing");
         rrd = 1;
         step;
         rrd = 0;
         step;
         chk(fl.regular_conv_done, 1'b0, "read did not clear");
         clear_all;
         chk({26'h0, fl}, 32'h0000_0000, "write one clear failed");
      end
      chk(t[0] >= 13 && t[0] <= 15, 1'b1, "12 bit conversion time");
      for (int r = 0; r < 3; r++)
         chk(t[r] - t[r + 1], 2, "resolution step time");
      ien = '0;
      $display("resolution test done");
      // retain mode keeps context, empty mode flushes it
      htrig = 1;
      step;
      htrig = 0;
      wait_flag(1, n);
      clear_all;
      chk(ctx, HW2, "retain mode lost context");
      wr(HW3);
      chk(fl.queue_overflow_flag, 1'b0, "write after done dropped");
      chk(ctx, HW2, "queued write changed active context");
      jstop = 1;
      step;
      chk(jst, 1'b0, "start not cleared by stop");
      jstop = 0;
      step;
      chk(ctx, HW2, "retain flush lost context");
      qmode = 1;
      dis = 1;
      step;
      dis = 0;
      step;
      chk(ctx, 32'h0000_0000, "empty flush kept context");
      jstart = 0;
      step;
      jstart = 1;
      step;
      htrig = 1;
      step;
      htrig = 0;
      step;
      chk(busy, 1'b0, "trigger served with empty queue");
      $display("flush test done");
      // software context starts on start rising edge
      jstart = 0;
      wr(SW1);
      chk(ctx, SW1, "software context not active");
      chk(busy, 1'b0, "started without edge");
      jstart = 1;
      step;
      step;
      chk(busy & is_inj, 1'b1, "software start missing");
      wait_flag(1, n);
      chk(ctx, 32'h0000_0000, "empty mode kept drained context");
      clear_all;
      $display("software trigger test done");
      // retain-mode start procedure with a dummy hardware context
      qmode = 0;
      jstart = 0;
      wr(HW1);
      jstart = 1;
      step;
      jstop = 1;
      step;
      chk(jst, 1'b0, "start echo not cleared by stop");
      jstop = 0;
      jstart = 0;
      step;
      jstart = 1;
      step;
      step;
      chk(busy, 1'b0, "hardware context started by start bit");
      chk(ctx, HW1, "dummy context not retained");
      $display("start procedure test done");
      tally_and_finish;
   end
endmodule : testbench
`default_nettype wire
